// ==== logic/tcbp_bus_port.sv ====
// Bus port, shared RAM arbitration, watchdog and port decode
`timescale 1ns/100ps
module tcbp_bus_port #(
  parameter int unsigned WDOG_CYCLES = tcbp_pkg::WDOG_CYCLES
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [tcbp_pkg::CARD_W-1:0] card_addr,
  input wire logic [tcbp_pkg::BUS_ADDR_W-1:0] bus_addr,
  input wire logic bus_read,
  input wire logic bus_write,
  input wire logic bus_reset,
  input wire logic [tcbp_pkg::DATA_W-1:0] bus_data_in,
  output logic [tcbp_pkg::DATA_W-1:0] bus_data_out,
  output logic bus_data_oe_n,
  output logic bus_done_ack,
  input wire logic cpu_req,
  input wire logic cpu_io,
  input wire logic cpu_write,
  input wire logic [tcbp_pkg::BUS_ADDR_W-1:0] cpu_addr,
  input wire logic [tcbp_pkg::DATA_W-1:0] cpu_wdata,
  input wire logic soft_reset_req,
  output logic [tcbp_pkg::DATA_W-1:0] cpu_rdata,
  output logic cpu_done,
  output logic cpu_reset_n,
  output logic processor_ram_window,
  output logic bus_ram_window,
  output logic bus_cycle_end,
  output logic [tcbp_pkg::BUS_ADDR_W-1:0] ram_addr,
  output logic [tcbp_pkg::DATA_W-1:0] ram_wdata,
  output logic ram_we,
  input wire logic [tcbp_pkg::DATA_W-1:0] ram_rdata,
  output logic [tcbp_pkg::NUM_PORTS-1:0] usart_select,
  output logic [tcbp_pkg::NUM_PORTS-1:0] port_current_loop,
  output logic [tcbp_pkg::NUM_PORTS-1:0] loop_tx_enable,
  output logic watchdog_restart_strobe,
  output logic baud_tick
);

  // ****************************************
  // Decode functions
  // ****************************************
  function automatic logic [tcbp_pkg::BUS_ADDR_W-1:0] xlate(
    input logic [tcbp_pkg::BUS_ADDR_W-1:0] a);
    logic [tcbp_pkg::PORT_W-1:0] port;
    logic [tcbp_pkg::LOC_W-1:0] loc;
    port = a[tcbp_pkg::PORT_LSB +: tcbp_pkg::PORT_W];
    loc = a[tcbp_pkg::LOC_W-1:0];
    xlate = tcbp_pkg::BUS_RAM_BASE | {{tcbp_pkg::BUS_ADDR_W-tcbp_pkg::PORT_W-tcbp_pkg::LOC_W{1'b0}},
      port, loc};
  endfunction : xlate

  function automatic logic [tcbp_pkg::IO_SEL_W-1:0] io_sel(
    input logic [tcbp_pkg::BUS_ADDR_W-1:0] a);
    io_sel = a[tcbp_pkg::IO_SEL_LSB +: tcbp_pkg::IO_SEL_W];
  endfunction : io_sel

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int PIN_W = tcbp_pkg::CARD_W + 3 + tcbp_pkg::BUS_ADDR_W + tcbp_pkg::DATA_W;
  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_sync_reg;
  logic [tcbp_pkg::CARD_W-1:0] card_s;
  logic bus_reset_s;
  logic bus_write_s;
  logic bus_read_s;
  logic [tcbp_pkg::BUS_ADDR_W-1:0] bus_addr_s;
  logic [tcbp_pkg::DATA_W-1:0] bus_data_s;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= {card_addr, bus_reset, bus_write, bus_read, bus_addr, bus_data_in};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  assign {card_s, bus_reset_s, bus_write_s, bus_read_s, bus_addr_s, bus_data_s} = pin_sync_reg;

  wire addr_match = (bus_addr_s[tcbp_pkg::CARD_LSB +: tcbp_pkg::CARD_W] == card_s);
  wire bus_req_s = bus_read_s || bus_write_s;

  // ****************************************
  // Bus control
  // ****************************************
  tcbp_pkg::tcbp_bs_state_t bs_reg;
  tcbp_pkg::tcbp_bs_state_t bs_next;
  logic [tcbp_pkg::DATA_W-1:0] bus_rdata_reg;
  logic bus_is_read_reg;
  logic bus_done_ack_reg;
  logic bus_data_oe_n_reg;
  logic cycle_end_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [tcbp_pkg::REQ_W-1:0] fifo_out_data;

  wire fifo_in_valid = (bs_reg == tcbp_pkg::BS_IDLE) && addr_match && bus_req_s;
  wire [tcbp_pkg::REQ_W-1:0] fifo_in_data = {bus_write_s, bus_addr_s, bus_data_s};

  always_comb begin
    bs_next = bs_reg;
    case (bs_reg)
      tcbp_pkg::BS_IDLE: if (fifo_in_valid && fifo_in_ready) bs_next = tcbp_pkg::BS_WAIT;
      tcbp_pkg::BS_WAIT: if (cycle_end_reg) bs_next = tcbp_pkg::BS_ACK;
      tcbp_pkg::BS_ACK: if (!bus_req_s) bs_next = tcbp_pkg::BS_IDLE;
      default: bs_next = tcbp_pkg::BS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bs_reg <= tcbp_pkg::BS_IDLE;
      bus_is_read_reg <= 1'b0;
      bus_done_ack_reg <= 1'b0;
      bus_data_oe_n_reg <= 1'b1;
    end else begin
      bs_reg <= bs_next;
      if (fifo_in_valid && fifo_in_ready) bus_is_read_reg <= !bus_write_s;
      bus_done_ack_reg <= (bs_next == tcbp_pkg::BS_ACK);
      bus_data_oe_n_reg <= !((bs_next == tcbp_pkg::BS_ACK) && bus_is_read_reg);
    end
  end

  tcbp_fifo #(
    .WIDTH(tcbp_pkg::REQ_W),
    .DEPTH(tcbp_pkg::FIFO_DEPTH)
  ) u_req_fifo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ****************************************
  // RAM control windows
  // ****************************************
  tcbp_pkg::tcbp_rc_state_t rc_reg;
  tcbp_pkg::tcbp_rc_state_t rc_next;
  logic cpu_pend_reg;
  logic cpu_io_reg;
  logic cpu_write_reg;
  logic [tcbp_pkg::BUS_ADDR_W-1:0] cpu_addr_reg;
  logic [tcbp_pkg::DATA_W-1:0] cpu_wdata_reg;
  logic [tcbp_pkg::BUS_ADDR_W-1:0] ram_addr_reg;
  logic [tcbp_pkg::DATA_W-1:0] ram_wdata_reg;
  logic ram_we_reg;
  logic bus_serv_reg;
  logic [tcbp_pkg::DATA_W-1:0] cpu_rdata_reg;
  logic cpu_done_reg;
  logic [tcbp_pkg::NUM_PORTS-1:0] port_mode_reg;

  wire head_write = fifo_out_data[tcbp_pkg::REQ_W-1];
  wire [tcbp_pkg::BUS_ADDR_W-1:0] head_addr = fifo_out_data[tcbp_pkg::DATA_W +: tcbp_pkg::BUS_ADDR_W];
  wire [tcbp_pkg::DATA_W-1:0] head_data = fifo_out_data[tcbp_pkg::DATA_W-1:0];
  wire proc_sel_next = (rc_next == tcbp_pkg::RC_PROC);
  // Bus address maps to BUS_RAM_BASE plus port and location bits on the local side
  wire [tcbp_pkg::BUS_ADDR_W-1:0] bus_local_addr = xlate(head_addr);
  wire [tcbp_pkg::BUS_ADDR_W-1:0] mux_addr = proc_sel_next ? cpu_addr_reg : bus_local_addr;
  wire proc_mem_we = cpu_write_reg && !cpu_io_reg;
  wire mux_we = proc_sel_next ? proc_mem_we : (fifo_out_valid && head_write);
  wire [tcbp_pkg::DATA_W-1:0] mux_wdata = proc_sel_next ? cpu_wdata_reg : head_data;
  assign fifo_out_ready = (rc_reg == tcbp_pkg::RC_BUS) && bus_serv_reg;

  // Processor requests are polled, never interrupt driven
  always_comb begin
    rc_next = rc_reg;
    case (rc_reg)
      tcbp_pkg::RC_IDLE: begin
        if (cpu_pend_reg) rc_next = tcbp_pkg::RC_PROC;
        else if (fifo_out_valid) rc_next = tcbp_pkg::RC_BUS;
      end
      tcbp_pkg::RC_PROC: rc_next = tcbp_pkg::RC_BUS;
      tcbp_pkg::RC_BUS: rc_next = tcbp_pkg::RC_IDLE;
      default: rc_next = tcbp_pkg::RC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rc_reg <= tcbp_pkg::RC_IDLE;
      cpu_pend_reg <= 1'b0;
      cpu_io_reg <= 1'b0;
      cpu_write_reg <= 1'b0;
      cpu_addr_reg <= '0;
      cpu_wdata_reg <= '0;
    end else begin
      rc_reg <= rc_next;
      // A new request wins over the clear of the old one
      if (cpu_req) cpu_pend_reg <= 1'b1;
      else if (rc_next == tcbp_pkg::RC_PROC) cpu_pend_reg <= 1'b0;
      if (cpu_req) begin
        cpu_io_reg <= cpu_io;
        cpu_write_reg <= cpu_write;
        cpu_addr_reg <= cpu_addr;
        cpu_wdata_reg <= cpu_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ram_addr_reg <= '0;
      ram_wdata_reg <= '0;
      ram_we_reg <= 1'b0;
      bus_serv_reg <= 1'b0;
      cycle_end_reg <= 1'b0;
      bus_rdata_reg <= '0;
      cpu_rdata_reg <= '0;
      cpu_done_reg <= 1'b0;
    end else begin
      ram_addr_reg <= mux_addr;
      ram_wdata_reg <= mux_wdata;
      ram_we_reg <= (rc_next != tcbp_pkg::RC_IDLE) && mux_we;
      bus_serv_reg <= (rc_next == tcbp_pkg::RC_BUS) && fifo_out_valid;
      cycle_end_reg <= fifo_out_ready;
      if (fifo_out_ready) bus_rdata_reg <= ram_rdata;
      cpu_done_reg <= (rc_reg == tcbp_pkg::RC_PROC);
      if (rc_reg == tcbp_pkg::RC_PROC) begin
        cpu_rdata_reg <= cpu_io_reg ? {{tcbp_pkg::DATA_W-tcbp_pkg::NUM_PORTS{1'b0}},
          port_mode_reg} : ram_rdata;
      end
    end
  end

  // ****************************************
  // Processor I/O decode
  // ****************************************
  logic [tcbp_pkg::NUM_PORTS-1:0] usart_sel_reg;
  logic wdog_strobe_reg;
  wire io_cycle = (rc_reg == tcbp_pkg::RC_PROC) && cpu_io_reg;
  wire [tcbp_pkg::IO_SEL_W-1:0] io_code = io_sel(cpu_addr_reg);
  wire mode_wr = io_cycle && cpu_write_reg && (io_code == tcbp_pkg::IO_PORT_MODE);
  wire wdog_hit = io_cycle && (io_code == tcbp_pkg::IO_WDOG_RESTART);
  logic [tcbp_pkg::NUM_PORTS-1:0] usart_sel_next;

  // Transceiver selects, disabled ports never selected
  genvar gp;
  generate
    for (gp = 0; gp < tcbp_pkg::NUM_PORTS; gp++) begin : g_port
      assign usart_sel_next[gp] = io_cycle && (io_code == tcbp_pkg::IO_SEL_W'(gp))
        && tcbp_pkg::PORT_ENABLE_MASK[gp];
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_mode_reg <= tcbp_pkg::PORT_MODE_RESET;
      usart_sel_reg <= '0;
      wdog_strobe_reg <= 1'b0;
    end else begin
      if (mode_wr) port_mode_reg <= cpu_wdata_reg[tcbp_pkg::NUM_PORTS-1:0]
        & tcbp_pkg::PORT_ENABLE_MASK;
      usart_sel_reg <= usart_sel_next;
      wdog_strobe_reg <= wdog_hit;
    end
  end

  // ****************************************
  // Common baud enable
  // ****************************************
  logic [tcbp_pkg::BAUD_CNT_W-1:0] baud_cnt_reg;
  logic baud_tick_reg;
  wire baud_wrap = (baud_cnt_reg == tcbp_pkg::BAUD_CNT_W'(tcbp_pkg::BAUD_DIV - 1));
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      baud_cnt_reg <= '0;
      baud_tick_reg <= 1'b0;
    end else begin
      baud_cnt_reg <= baud_wrap ? '0 : baud_cnt_reg + 1'b1;
      baud_tick_reg <= baud_wrap;
    end
  end

  // ****************************************
  // Watchdog and reset sources
  // ****************************************
  logic [tcbp_pkg::WDOG_CNT_W-1:0] wdog_cnt_reg;
  logic [tcbp_pkg::RST_CNT_W-1:0] rst_cnt_reg;
  logic cpu_reset_n_reg;
  wire wdog_expire = (wdog_cnt_reg == tcbp_pkg::WDOG_CNT_W'(WDOG_CYCLES - 1));
  wire ext_reset = bus_reset_s && addr_match;
  wire reset_cause = ext_reset || wdog_expire || soft_reset_req;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdog_cnt_reg <= '0;
      rst_cnt_reg <= tcbp_pkg::RST_CNT_W'(tcbp_pkg::RST_HOLD_CYCLES);
      cpu_reset_n_reg <= 1'b0;
    end else begin
      if (wdog_strobe_reg || !cpu_reset_n_reg || wdog_expire) wdog_cnt_reg <= '0;
      else wdog_cnt_reg <= wdog_cnt_reg + 1'b1;
      if (reset_cause) rst_cnt_reg <= tcbp_pkg::RST_CNT_W'(tcbp_pkg::RST_HOLD_CYCLES);
      else if (rst_cnt_reg != '0) rst_cnt_reg <= rst_cnt_reg - 1'b1;
      cpu_reset_n_reg <= !reset_cause && (rst_cnt_reg == '0);
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bus_data_out = bus_rdata_reg;
  assign bus_data_oe_n = bus_data_oe_n_reg;
  assign bus_done_ack = bus_done_ack_reg;
  assign cpu_rdata = cpu_rdata_reg;
  assign cpu_done = cpu_done_reg;
  assign cpu_reset_n = cpu_reset_n_reg;
  assign processor_ram_window = rc_reg[1];
  assign bus_ram_window = rc_reg[2];
  assign bus_cycle_end = cycle_end_reg;
  assign ram_addr = ram_addr_reg;
  assign ram_wdata = ram_wdata_reg;
  assign ram_we = ram_we_reg;
  assign usart_select = usart_sel_reg;
  assign port_current_loop = port_mode_reg;
  assign loop_tx_enable = port_mode_reg;
  assign watchdog_restart_strobe = wdog_strobe_reg;
  assign baud_tick = baud_tick_reg;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_proc_win;
    processor_ram_window;
  endsequence
  sequence s_bus_win;
    bus_ram_window && !processor_ram_window;
  endsequence

  a_ack_after_end: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(bus_done_ack) |-> $past(bus_cycle_end)) else $error("ack without cycle end");
  a_ack_hold_req: assert property (@(posedge sys_clk) disable iff (!arst_n)
    bus_done_ack && bus_req_s |=> bus_done_ack) else $error("ack dropped early");
  a_ack_release: assert property (@(posedge sys_clk) disable iff (!arst_n)
    bus_done_ack && !bus_req_s |=> !bus_done_ack) else $error("ack not released");
  a_push_starts_cycle: assert property (@(posedge sys_clk) disable iff (!arst_n)
    fifo_in_valid && fifo_in_ready |-> ##[1:4] bus_serv_reg) else $error("no memory cycle");
  a_no_match_idle: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (bs_reg == tcbp_pkg::BS_IDLE) && !addr_match |=> bs_reg == tcbp_pkg::BS_IDLE)
    else $error("access taken without match");
  a_window_order: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_proc_win |=> s_bus_win) else $error("bus window missing");
  a_mux_proc: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(processor_ram_window) |-> ram_addr == $past(cpu_addr_reg)) else $error("bad mux");
  a_mux_bus: assert property (@(posedge sys_clk) disable iff (!arst_n)
    bus_serv_reg |-> ram_addr == xlate(head_addr)) else $error("bad translation");
  a_wdog_restart: assert property (@(posedge sys_clk) disable iff (!arst_n)
    watchdog_restart_strobe |=> wdog_cnt_reg == '0) else $error("watchdog not restarted");
  a_wdog_expire: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wdog_expire |=> !cpu_reset_n ##1 !cpu_reset_n) else $error("watchdog reset missing");
  a_ext_reset: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ext_reset |=> !cpu_reset_n) else $error("bus reset ignored");
  a_ports_off: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (port_current_loop & ~tcbp_pkg::PORT_ENABLE_MASK) == '0 &&
    (usart_select & ~tcbp_pkg::PORT_ENABLE_MASK) == '0) else $error("disabled port active");
  a_loop_tx_off: assert property (@(posedge sys_clk) disable iff (!arst_n)
    mode_wr && !cpu_wdata_reg[0] |=> !loop_tx_enable[0]) else $error("loop tx on while off");

endmodule : tcbp_bus_port

// ==== shared/tcbp_pkg.sv ====
// Constants and types for the terminal controller bus port
package tcbp_pkg;

  // ****************************************
  // Bus fields
  // ****************************************
  localparam int BUS_ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int CARD_W = 4;
  localparam int CARD_LSB = 12;
  localparam int PORT_LSB = 10;
  localparam int PORT_W = 2;
  localparam int LOC_W = 10;
  localparam int NUM_PORTS = 4;
  localparam logic [NUM_PORTS-1:0] PORT_ENABLE_MASK = 4'h1;

  // ****************************************
  // Shared RAM layout
  // ****************************************
  localparam logic [BUS_ADDR_W-1:0] BUS_RAM_BASE = 16'h8000;
  localparam int FIFO_DEPTH = 4;
  localparam int REQ_W = 1 + BUS_ADDR_W + DATA_W;

  // ****************************************
  // Processor I/O map (bits 7:4 of I/O address)
  // ****************************************
  localparam int IO_SEL_W = 4;
  localparam int IO_SEL_LSB = 4;
  localparam logic [IO_SEL_W-1:0] IO_USART_LAST = 4'h3;
  localparam logic [IO_SEL_W-1:0] IO_PORT_MODE = 4'h4;
  localparam logic [IO_SEL_W-1:0] IO_WDOG_RESTART = 4'h5;
  localparam logic [NUM_PORTS-1:0] PORT_MODE_RESET = 4'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int WDOG_TIMEOUT_MS = 100;
  localparam int WDOG_CYCLES = WDOG_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int WDOG_CNT_W = 25;
  localparam int RST_HOLD_CYCLES = 16;
  localparam int RST_CNT_W = 5;
  localparam int BAUD_DIV = 16;
  localparam int BAUD_CNT_W = 4;

  // ****************************************
  // State machines
  // ****************************************
  typedef enum logic [2:0] {
    RC_IDLE = 3'h1,
    RC_PROC = 3'h2,
    RC_BUS = 3'h4
  } tcbp_rc_state_t;

  typedef enum logic [2:0] {
    BS_IDLE = 3'h1,
    BS_WAIT = 3'h2,
    BS_ACK = 3'h4
  } tcbp_bs_state_t;

endpackage : tcbp_pkg

// ==== logic/tcbp_fifo.sv ====
// Request FIFO between bus control and RAM control
`timescale 1ns/100ps
module tcbp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W:0] wr_ptr_reg;
  logic [PTR_W:0] rd_ptr_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [PTR_W:0] fill = wr_ptr_reg - rd_ptr_reg;

  assign in_ready = (fill != (PTR_W+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data = mem_reg[rd_ptr_reg[PTR_W-1:0]];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) mem_reg[wr_ptr_reg[PTR_W-1:0]] <= in_data;
  end

endmodule : tcbp_fifo

// ==== bench/tcbp_ioc_model.sv ====
// Behavioural io_controller driving the parallel bus
`timescale 1ns/100ps
module tcbp_ioc_model (
  input wire logic sys_clk,
  input wire logic bus_done_ack,
  input wire logic [7:0] bus_data_out,
  input wire logic bus_data_oe_n,
  output logic [15:0] bus_addr,
  output logic bus_read,
  output logic bus_write,
  output logic [7:0] bus_data_in,
  output logic bus_reset
);
  initial begin
    bus_addr = 16'h0000;
    bus_read = 1'b0;
    bus_write = 1'b0;
    bus_data_in = 8'h00;
    bus_reset = 1'b0;
  end
  // One transfer; hold stretches the request past the acknowledge
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d,
                      input int hold, output logic [7:0] q, output logic ok);
    ok = 1'b0;
    q = 8'h00;
    @(posedge sys_clk);
    #1;
    bus_addr = a;
    bus_data_in = d;
    bus_write = wr;
    bus_read = !wr;
    for (int n = 0; n < 30 && !ok; n++) begin
      @(posedge sys_clk);
      if (bus_done_ack === 1'b1) begin
        // Data driver on only for reads
        ok = (bus_data_oe_n === wr);
        q = bus_data_out;
      end
    end
    repeat (hold) @(posedge sys_clk);
    #1;
    bus_read = 1'b0;
    bus_write = 1'b0;
    bus_addr = ~a;
    bus_data_in = ~d;
    for (int n = 0; n < 10 && bus_done_ack !== 1'b0; n++) @(posedge sys_clk);
  endtask : xfer
  task automatic rst_pulse(input logic [15:0] a);
    @(posedge sys_clk);
    #1;
    bus_addr = a;
    bus_reset = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    bus_reset = 1'b0;
    bus_addr = ~a;
  endtask : rst_pulse
endmodule : tcbp_ioc_model

// ==== bench/tcbp_bus_port_tb.sv ====
// Self-checking bench for the terminal controller bus port
`timescale 1ns/100ps
module tcbp_bus_port_tb;
  logic sys_clk, arst_n, bus_read, bus_write, bus_reset, bus_data_oe_n, bus_done_ack;
  logic [3:0] card_addr, usart_select, port_current_loop, loop_tx_enable;
  logic [15:0] bus_addr, cpu_addr, ram_addr;
  logic [7:0] bus_data_in, bus_data_out, cpu_wdata, cpu_rdata, ram_wdata, ram_rdata;
  logic cpu_req, cpu_io, cpu_write, soft_reset_req, cpu_done, cpu_reset_n, ram_we;
  logic processor_ram_window, bus_ram_window, bus_cycle_end;
  logic watchdog_restart_strobe, baud_tick;
  logic [7:0] mem [0:65535];
  logic [7:0] q;
  logic [3:0] sel;
  logic ok, wd;
  int num_errors, checked, n;
  tcbp_bus_port #(.WDOG_CYCLES(1000)) DUT (.sys_clk, .arst_n, .card_addr, .bus_addr,
    .bus_read, .bus_write, .bus_reset, .bus_data_in, .bus_data_out, .bus_data_oe_n,
    .bus_done_ack, .cpu_req, .cpu_io, .cpu_write, .cpu_addr, .cpu_wdata, .soft_reset_req,
    .cpu_rdata, .cpu_done, .cpu_reset_n, .processor_ram_window, .bus_ram_window,
    .bus_cycle_end, .ram_addr, .ram_wdata, .ram_we, .ram_rdata, .usart_select,
    .port_current_loop, .loop_tx_enable, .watchdog_restart_strobe, .baud_tick);
  tcbp_ioc_model ioc (.sys_clk, .bus_done_ack, .bus_data_out, .bus_data_oe_n, .bus_addr, .bus_read,
    .bus_write, .bus_data_in, .bus_reset);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  assign ram_rdata = mem[ram_addr];
  always @(posedge sys_clk) begin
    if (ram_we) mem[ram_addr] <= ram_wdata;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wait_rst(input logic lvl, input int lim, output int k);
    for (k = 0; k < lim && cpu_reset_n !== lvl; k++) @(posedge sys_clk);
  endtask : wait_rst
  // Processor cycle; collects strobes and checks the window order
  task automatic cpu(input logic io, input logic wr, input logic [15:0] a,
                     input logic [7:0] d);
    logic pw;
    logic done;
    pw = 1'b0;
    done = 1'b0;
    sel = 4'h0;
    wd = 1'b0;
    @(posedge sys_clk);
    #1;
    cpu_req = 1'b1;
    cpu_io = io;
    cpu_write = wr;
    cpu_addr = a;
    cpu_wdata = d;
    @(posedge sys_clk);
    #1;
    cpu_req = 1'b0;
    repeat (8) begin
      if (pw === 1'b1) chk(bus_ram_window, 1, "bus window");
      if (processor_ram_window === 1'b1 && !io) chk(ram_addr, a, "mux addr");
      pw = processor_ram_window;
      sel |= usart_select;
      wd |= watchdog_restart_strobe;
      if (cpu_done === 1'b1) begin
        done = 1'b1;
        q = cpu_rdata;
      end
      @(posedge sys_clk);
      #1;
    end
    chk(done, 1, "cpu done");
  endtask : cpu
  task automatic t_bus();
    logic [15:0] a;
    cpu(1, 0, 16'h0050, 8'h00);
    for (int p = 0; p < 4; p++) begin
      a = {card_addr, p[1:0], 10'h3C0 + 10'(p)};
      ioc.xfer(1, a, 8'h50 + 8'(p), p, q, ok);
      chk(ok, 1, "write ack");
      chk(mem[16'h8000 | {4'h0, a[11:0]}], 8'h50 + 8'(p), "ram byte");
      ioc.xfer(0, a, 8'h00, 3 - p, q, ok);
      chk({ok, q}, {1'b1, 8'h50 + 8'(p)}, "read data");
      chk(bus_done_ack, 0, "ack dropped");
      cpu(0, 0, 16'h8000 | {4'h0, a[11:0]}, 8'h00);
      chk(q, 8'h50 + 8'(p), "shared byte");
    end
    for (int b = 0; b < 4; b++) begin
      ioc.xfer(0, {card_addr ^ (4'h1 << b), 12'h001}, 8'h00, 0, q, ok);
      chk(ok, 0, "foreign card");
    end
    $display("test bus done");
  endtask : t_bus
  task automatic t_ports();
    cpu(1, 1, 16'h0040, 8'hFF);
    cpu(1, 0, 16'h0040, 8'h00);
    chk(q[3:0], 4'h1, "mode readback");
    chk(port_current_loop, 4'h1, "loop sel");
    chk(loop_tx_enable, 4'h1, "loop tx on");
    cpu(1, 1, 16'h0040, 8'h00);
    chk(loop_tx_enable, 4'h0, "loop tx off");
    for (int c = 0; c < 4; c++) begin
      cpu(1, 0, {8'h00, 4'(c), 4'h0}, 8'h00);
      chk(sel, (c == 0) ? 4'h1 : 4'h0, "usart select");
    end
    @(posedge baud_tick);
    for (n = 1; n < 40; n++) begin
      @(posedge sys_clk);
      #1;
      if (baud_tick === 1'b1) break;
    end
    chk(n, 16, "baud spacing");
    $display("test ports done");
  endtask : t_ports
  task automatic t_wdog();
    repeat (3) begin
      cpu(1, 0, 16'h0050, 8'h00);
      chk(wd, 1, "restart strobe");
      wait_rst(0, 600, n);
      chk(n, 600, "no early reset");
    end
    cpu(1, 0, 16'h0050, 8'h00);
    wait_rst(0, 1100, n);
    chk(n >= 880 && n < 1100, 1, "watchdog fire");
    wait_rst(1, 40, n);
    ioc.rst_pulse({~card_addr, 12'h000});
    wait_rst(0, 20, n);
    chk(n, 20, "foreign reset");
    ioc.rst_pulse({card_addr, 12'h000});
    wait_rst(0, 20, n);
    chk(n < 20, 1, "bus reset");
    wait_rst(1, 40, n);
    #1;
    soft_reset_req = 1'b1;
    @(posedge sys_clk);
    #1;
    soft_reset_req = 1'b0;
    wait_rst(0, 10, n);
    chk(n < 10, 1, "soft reset");
    wait_rst(1, 40, n);
    $display("test watchdog done");
  endtask : t_wdog
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    {arst_n, cpu_req, cpu_io, cpu_write, soft_reset_req} = 5'h00;
    card_addr = 4'h9;
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    repeat (2) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    chk(cpu_reset_n, 0, "hold after reset");
    wait_rst(1, 40, n);
    chk(n >= 15 && n < 20, 1, "reset release");
    t_bus();
    t_ports();
    t_wdog();
    end_sim();
  end
endmodule : tcbp_bus_port_tb
